// ===== src/socket_power_clock_control.sv
// Socket supply requests and card clock stop or slow control with APB access
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module socket_power_clock_control
    import sock_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        socket_idle,
    input  wire logic        host_clkrun_stopping,
    input  wire logic        card_access,
    input  wire logic        cardbus_card,
    input  wire logic [3:0]  card_volt_class,
    output logic             sense_request,
    output logic [2:0]       vcc_applied,
    output logic [2:0]       vpp_applied,
    output logic             card_clk_en,
    output logic             irq
);
    logic [2:0]  vcc_req_reg;
    logic [2:0]  vpp_req_reg;
    logic        stop_policy_reg;
    logic        throttle_en_reg;
    logic        slow_sel_reg;
    logic        access_seen_reg;
    logic        ctrl_enabled_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [3:0]  class_s1_reg;
    logic [3:0]  class_s2_reg;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic [3:0]  div_reg;
    clk_state_t  clk_state_reg;
    clk_state_t  clk_state_next;

    logic wr_en;
    logic rd_en;
    logic idle_s;
    logic host_stop_s;
    logic access_s;
    logic may_throttle;
    logic slow_eff;
    logic vcc_ok;
    logic vpp_ok;
    logic rate_changed;
    logic [IRQ_W-1:0] irq_events;

    // All checks below live in the bus clock domain
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Card-side status comes from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg    <= 3'h0;
            sync2_reg    <= 3'h0;
            class_s1_reg <= 4'h0;
            class_s2_reg <= 4'h0;
        end else begin
            sync1_reg    <= {card_access, host_clkrun_stopping, socket_idle};
            sync2_reg    <= sync1_reg;
            class_s1_reg <= card_volt_class;
            class_s2_reg <= class_s1_reg;
        end
    end
    assign idle_s      = sync2_reg[0];
    assign host_stop_s = sync2_reg[1];
    assign access_s    = sync2_reg[2];

    // Class bits: [0] 5 V, [1] 3.3 V, [2] X.X V, [3] Y.Y V
    always_comb begin
        case (vcc_req_reg)
            SUP_OFF: vcc_ok = 1'b1;
            SUP_5V:  vcc_ok = class_s2_reg[0] || !cardbus_card;
            SUP_3V3: vcc_ok = class_s2_reg[1];
            SUP_XV:  vcc_ok = class_s2_reg[2];
            SUP_YV:  vcc_ok = class_s2_reg[3];
            default: vcc_ok = 1'b0;
        endcase
        case (vpp_req_reg)
            SUP_OFF, SUP_12V, SUP_5V, SUP_3V3, SUP_XV, SUP_YV:
                vpp_ok = 1'b1;
            default: vpp_ok = 1'b0;
        endcase
    end

    // Control register fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vcc_req_reg     <= CTRL_RESET[VCC_LSB+:3];
            vpp_req_reg     <= CTRL_RESET[VPP_LSB+:3];
            stop_policy_reg <= CTRL_RESET[STOP_POLICY_BIT];
        end else if (wr_en && paddr == CTRL_OFFSET && ctrl_enabled_reg) begin
            vcc_req_reg     <= pwdata[VCC_LSB+:3];
            vpp_req_reg     <= pwdata[VPP_LSB+:3];
            stop_policy_reg <= pwdata[STOP_POLICY_BIT];
        end
    end

    // Applied supplies only follow requests that are legal and suitable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vcc_applied <= SUP_OFF;
            vpp_applied <= SUP_OFF;
        end else if (vcc_ok && vpp_ok) begin
            vcc_applied <= vcc_req_reg;
            vpp_applied <= vpp_req_reg;
        end
    end

    // Retest re-enables control; forced class bits disable it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enabled_reg <= 1'b1;
            sense_request    <= 1'b0;
        end else begin
            sense_request <= 1'b0;
            if (wr_en && paddr == RETEST_OFFSET) begin
                if (pwdata[RETEST_BIT]) begin
                    ctrl_enabled_reg <= 1'b1;
                    sense_request    <= 1'b1;
                end else if (|pwdata[FORCE_LSB+:4]) begin
                    ctrl_enabled_reg <= 1'b0;
                end
            end
        end
    end

    // Power management register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            throttle_en_reg <= PM_RESET[THROTTLE_EN_BIT];
            slow_sel_reg    <= PM_RESET[SLOW_SEL_BIT];
        end else if (wr_en && paddr == PM_OFFSET) begin
            throttle_en_reg <= pwdata[THROTTLE_EN_BIT];
            slow_sel_reg    <= pwdata[SLOW_SEL_BIT];
        end
    end

    // Set wins over the read clear so no access is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_seen_reg <= 1'b0;
        end else if (access_s) begin
            access_seen_reg <= 1'b1;
        end else if (rd_en && paddr == PM_OFFSET) begin
            access_seen_reg <= 1'b0;
        end
    end

    assign slow_eff = throttle_en_reg && slow_sel_reg;
    assign may_throttle = idle_s && (stop_policy_reg || host_stop_s);

    always_comb begin
        clk_state_next = clk_state_reg;
        case (clk_state_reg)
            CLK_RUN: begin
                if (may_throttle) begin
                    clk_state_next = slow_eff ? CLK_SLOW : CLK_STOP;
                end
            end
            CLK_STOP, CLK_SLOW: begin
                // Select changes take effect while the card stays idle
                if (!may_throttle) begin
                    clk_state_next = CLK_RUN;
                end else begin
                    clk_state_next = slow_eff ? CLK_SLOW : CLK_STOP;
                end
            end
            default: clk_state_next = CLK_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_state_reg <= CLK_RUN;
        end else begin
            clk_state_reg <= clk_state_next;
        end
    end

    // Divider gives one enable pulse in sixteen while slowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 4'h0;
        end else if (clk_state_reg == CLK_SLOW) begin
            div_reg <= div_reg + 4'h1;
        end else begin
            div_reg <= 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_clk_en <= 1'b1;
        end else begin
            case (clk_state_next)
                CLK_STOP: card_clk_en <= 1'b0;
                CLK_SLOW: card_clk_en <= (div_reg == SLOW_DIV_LAST);
                default:  card_clk_en <= 1'b1;
            endcase
        end
    end

    assign rate_changed = (clk_state_reg != CLK_RUN);

    // Events: access seen, clock throttled, supply request refused
    assign irq_events = {!(vcc_ok && vpp_ok), rate_changed, access_s};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (wr_en && paddr == IRQ_STAT_OFFSET) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr_en && paddr == IRQ_MASK_OFFSET) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read data; unmapped addresses read zero
    always_comb begin
        prdata = 32'h00000000;
        if (paddr == CTRL_OFFSET) begin
            prdata[STOP_POLICY_BIT]  = stop_policy_reg;
            prdata[VCC_LSB+:3]       = vcc_req_reg;
            prdata[VPP_LSB+:3]       = vpp_req_reg;
        end else if (paddr == PM_OFFSET) begin
            prdata[ACCESS_SEEN_BIT]  = access_seen_reg;
            prdata[RATE_CHANGED_BIT] = rate_changed;
            prdata[THROTTLE_EN_BIT]  = throttle_en_reg;
            prdata[SLOW_SEL_BIT]     = slow_sel_reg;
        end else if (paddr == IRQ_STAT_OFFSET) begin
            prdata[IRQ_W-1:0]        = irq_stat_reg;
        end else if (paddr == IRQ_MASK_OFFSET) begin
            prdata[IRQ_W-1:0]        = irq_mask_reg;
        end
    end

    a_access_set: assert property (access_s |=> access_seen_reg)
        else $error("access seen flag not set");
    a_read_clear: assert property (
        rd_en && paddr == PM_OFFSET && !access_s |=> !access_seen_reg)
        else $error("access seen flag not cleared by read");
    a_policy_gate: assert property (
        clk_state_reg == CLK_RUN && !stop_policy_reg && !host_stop_s
        |=> clk_state_reg == CLK_RUN)
        else $error("clock throttled without host stop");
    a_idle_throttle: assert property (
        clk_state_reg == CLK_RUN && stop_policy_reg && idle_s
        |=> clk_state_reg != CLK_RUN)
        else $error("idle socket not throttled");
    a_stop_default: assert property (
        clk_state_reg == CLK_RUN && may_throttle && !throttle_en_reg
        |=> clk_state_reg == CLK_STOP && !card_clk_en)
        else $error("throttle disabled but not stopped");
    // Leaving the slowed state may keep the enable high, which is legal
    a_slow_pulse: assert property (
        clk_state_reg == CLK_SLOW && $past(clk_state_reg) == CLK_SLOW
        && card_clk_en |=> !card_clk_en || clk_state_reg != CLK_SLOW)
        else $error("slowed clock pulse too wide");
    a_rate_flag: assert property (
        rd_en && paddr == PM_OFFSET
        |-> prdata[RATE_CHANGED_BIT] || card_clk_en)
        else $error("rate changed flag wrong");
    a_ctrl_resvd: assert property (
        paddr == CTRL_OFFSET |-> prdata[31:8] == 24'h0 && !prdata[3])
        else $error("control reserved bits not zero");
    a_pm_resvd: assert property (
        paddr == PM_OFFSET |-> prdata[31:26] == 6'h0
        && prdata[23:17] == 7'h0 && prdata[15:1] == 15'h0)
        else $error("power management reserved bits not zero");
    a_bad_supply: assert property (
        !(vcc_ok && vpp_ok) |=> $stable(vcc_applied)
        && $stable(vpp_applied))
        else $error("refused supply request applied");

    c_stop: cover property (clk_state_reg == CLK_STOP);
    c_slow: cover property (clk_state_reg == CLK_SLOW && card_clk_en);
    c_refuse: cover property (!vcc_ok);
endmodule

// ===== shared/sock_pkg.sv
// Package with register map, field layout and timing constants of the socket power and clock control
package sock_pkg;
    localparam logic [7:0]  CTRL_OFFSET     = 8'h10;
    localparam logic [7:0]  PM_OFFSET       = 8'h20;
    localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h30;
    localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h34;
    localparam logic [7:0]  RETEST_OFFSET   = 8'h38;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;
    localparam logic [31:0] PM_RESET        = 32'h00000000;
    localparam int STOP_POLICY_BIT  = 7;
    localparam int VCC_LSB          = 4;
    localparam int VPP_LSB          = 0;
    localparam int ACCESS_SEEN_BIT  = 25;
    localparam int RATE_CHANGED_BIT = 24;
    localparam int THROTTLE_EN_BIT  = 16;
    localparam int SLOW_SEL_BIT     = 0;
    localparam int RETEST_BIT       = 14;
    localparam int FORCE_LSB        = 10;
    localparam logic [3:0] SLOW_DIV_LAST = 4'hF;
    localparam int IRQ_W = 3;
    localparam logic [2:0] SUP_OFF  = 3'h0;
    localparam logic [2:0] SUP_12V  = 3'h1;
    localparam logic [2:0] SUP_5V   = 3'h2;
    localparam logic [2:0] SUP_3V3  = 3'h3;
    localparam logic [2:0] SUP_XV   = 3'h4;
    localparam logic [2:0] SUP_YV   = 3'h5;
    typedef enum logic [2:0] {
        CLK_RUN  = 3'b001,
        CLK_STOP = 3'b010,
        CLK_SLOW = 3'b100
    } clk_state_t;
endpackage

// ===== dv/card_model.sv
// Card model seen from the socket side
`timescale 1ns/1ps
module card_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       busy,
    input  wire logic       cb,
    input  wire logic [3:0] cls,
    output logic            card_access,
    output logic            socket_idle,
    output logic            cardbus_card,
    output logic [3:0]      card_volt_class
);
    // One access cycle per request from the bench
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_access <= 1'b0;
        end else begin
            card_access <= go;
        end
    end
    // Never idle while an access is pending, so the clock cannot stop under it
    assign socket_idle     = !busy && !card_access && !go;
    assign cardbus_card    = cb;
    assign card_volt_class = cls;
endmodule

// ===== dv/tb.sv
// Self-checking testbench for socket power and card clock control
`timescale 1ns/1ps
module tb;
    import sock_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, host_stop = 0, busy = 1, go = 0, cb = 1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, d;
    logic [3:0]  cls = 4'hF, card_volt_class;
    logic [2:0]  vcc_applied, vpp_applied;
    logic        pready, pslverr, socket_idle, card_access, cardbus_card;
    logic        sense_request, card_clk_en, irq;
    int          bad_count = 0, check_count = 0, sense_cnt = 0;
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (sense_request === 1'b1) sense_cnt++;
    socket_power_clock_control i_socket_power_clock_control (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .socket_idle(socket_idle),
        .host_clkrun_stopping(host_stop), .card_access(card_access),
        .cardbus_card(cardbus_card), .card_volt_class(card_volt_class),
        .sense_request(sense_request), .vcc_applied(vcc_applied),
        .vpp_applied(vpp_applied), .card_clk_en(card_clk_en), .irq(irq));
    card_model i_card_model (.pclk(pclk), .presetn(presetn), .go(go),
        .busy(busy), .cb(cb), .cls(cls), .card_access(card_access),
        .socket_idle(socket_idle), .cardbus_card(cardbus_card),
        .card_volt_class(card_volt_class));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        // Taken at the accepting edge, before that edge's updates land
        d = prdata;
        chk("slave error", 32'h00000000, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk("register read", e, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Counts clock enable highs; slow mode must give one in sixteen
    task automatic cnt(input int n, input int e);
        int k;
        k = 0;
        repeat (n) begin
            @(negedge pclk);
            k += int'(card_clk_en === 1'b1);
        end
        chk("card clock highs", e, k);
        @(posedge pclk);
    endtask
    task automatic t_reset;
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(PM_OFFSET, PM_RESET);
        rd(8'h44, 32'h00000000);
        chk("clock enable", 1, card_clk_en);
    endtask
    task automatic t_supply;
        logic [2:0] vc [5] = '{SUP_5V, SUP_3V3, SUP_XV, SUP_YV, SUP_OFF};
        logic [2:0] vp [5] = '{SUP_12V, SUP_5V, SUP_3V3, SUP_XV, SUP_YV};
        wr(CTRL_OFFSET, 32'hFFFFFFFF);
        rd(CTRL_OFFSET, 32'h000000F7);
        cyc(3);
        chk("vcc reserved", SUP_OFF, vcc_applied);
        chk("vpp reserved", SUP_OFF, vpp_applied);
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_OFFSET, {25'h0, vc[i], 1'b0, vp[i]});
            cyc(3);
            chk("vcc applied", vc[i], vcc_applied);
            chk("vpp applied", vp[i], vpp_applied);
        end
        cls <= 4'h2;
        cyc(5);
        wr(CTRL_OFFSET, 32'h00000021);
        cyc(3);
        chk("vcc unsuited", SUP_OFF, vcc_applied);
        chk("vpp held", SUP_YV, vpp_applied);
        wr(CTRL_OFFSET, 32'h00000036);
        cyc(3);
        chk("vcc held", SUP_OFF, vcc_applied);
        chk("vpp reserved", SUP_YV, vpp_applied);
        wr(CTRL_OFFSET, 32'h00000031);
        cyc(3);
        chk("vcc suited", SUP_3V3, vcc_applied);
        chk("vpp suited", SUP_12V, vpp_applied);
        cls <= 4'hF;
        wr(PM_OFFSET, 32'hFFFFFFFF);
        rd(PM_OFFSET, 32'h00010001);
    endtask
    task automatic t_access;
        wr(IRQ_STAT_OFFSET, 32'h00000007);
        wr(IRQ_MASK_OFFSET, 32'h00000000);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(4);
        chk("irq masked", 0, irq);
        rd(PM_OFFSET, 32'h02010001);
        rd(PM_OFFSET, 32'h00010001);
        wr(IRQ_MASK_OFFSET, 32'h00000001);
        chk("irq raised", 1, irq);
        wr(IRQ_STAT_OFFSET, 32'h00000001);
        chk("irq cleared", 0, irq);
    endtask
    task automatic t_clock;
        wr(PM_OFFSET, 32'h00000000);
        wr(CTRL_OFFSET, 32'h00000000);
        busy <= 1'b0;
        cyc(10);
        cnt(16, 16);
        rd(PM_OFFSET, 32'h00000000);
        host_stop <= 1'b1;
        cyc(8);
        cnt(16, 0);
        rd(PM_OFFSET, 32'h01000000);
        wr(PM_OFFSET, 32'h00000001);
        cyc(6);
        cnt(16, 0);
        wr(PM_OFFSET, 32'h00010001);
        cyc(6);
        cnt(48, 3);
        wr(CTRL_OFFSET, 32'h00000080);
        host_stop <= 1'b0;
        cyc(8);
        cnt(48, 3);
        busy <= 1'b1;
        cyc(8);
        cnt(16, 16);
        rd(PM_OFFSET, 32'h00010001);
    endtask
    task automatic t_retest;
        wr(RETEST_OFFSET, 32'h00000400);
        wr(CTRL_OFFSET, 32'h00000020);
        rd(CTRL_OFFSET, 32'h00000080);
        sense_cnt = 0;
        wr(RETEST_OFFSET, 32'h00004000);
        // One more edge so the pulse counter has settled
        cyc(1);
        chk("sense pulses", 1, sense_cnt);
        wr(CTRL_OFFSET, 32'h00000020);
        rd(CTRL_OFFSET, 32'h00000020);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        cyc(6);
        presetn <= 1'b1;
        cyc(1);
        t_reset();
        t_supply();
        t_access();
        t_clock();
        t_retest();
        complete_run();
    end
endmodule
